//--- hw/adc_irq_flags.sv
// Purpose: interrupt flags of the converter serial core
// Assumes: REF_CLK is the modulator clock; link strobes come from the
//          serial command decoder on SCK_CLK, one cycle each
// Notes:   flags are active low on the status byte and the register
// Operation
// - flags come from start, data ready, power-on and config check events
// - status flags snapshot together at address detect, sent each command
// - reported status flags clear when the status byte finishes
// - interrupt register at 0x5 snapshots at start of its read
// - reported register flags clear when that read finishes
// - source select 0 lets all sources drive pin, 1 only por and check
// - start event pulses pin low for a fixed short width
// - data ready pin released at first result read edge or, in continuous or scan mode, 16 before end
// - data ready event comes with each new result on modulator clock
// - status data ready shows 0 once after event, then 1
// - register data ready shows 0 after event until fully read
// - data ready drives pin low at once when selection allows
// - start event only on pin, enabled by a control bit
// - start pulse follows a 256 clock start-up delay
// - in scan mode start pulse only in first scan cycle
// - status power-up flag 0 in first byte after power-up, then 1
// - register power-up bit 0 after power-up, 1 after full read
// - por pin cleared by chip select fall with both supplies good
// - check error pin cleared by unlock or fast start command
// - no serial response and no flag reads while in power-on state
// - check error held on all three paths until unlock or fast start command
// - check error beats all but por on pin, and beats bitstream output
`timescale 1ns/1ps
`default_nettype none
module adc_irq_flags #(
	parameter int STP_WIDTH = irq_flag_pkg::STP_WIDTH_DEF // start pulse cycles
) (
	input  wire logic        REF_CLK,            // modulator clock
	input  wire logic        RESETN,             // sync reset, active low
	input  wire logic        SCK_CLK,            // serial link clock
	input  wire logic        CS_N,               // chip select pin
	input  wire logic        AVDD_OK,            // analog supply monitor
	input  wire logic        DVDD_OK,            // digital supply monitor
	input  wire logic        LK_ADDR_HIT,        // device address detected
	input  wire logic        LK_STATUS_END,      // status byte last edge
	input  wire logic        LK_IRQ_RD_START,    // flag register read begins
	input  wire logic        LK_IRQ_RD_END,      // flag register read ends
	input  wire logic        LK_DATA_RD_EDGE,    // first edge of result read
	input  wire logic        LK_FAST_START,      // fast start/restart command
	input  wire logic        CONV_KICK,          // conversion sequence begins
	input  wire logic        CONV_DONE,          // new conversion_result
	input  wire logic        CONT_MODE,          // continuous conversion
	input  wire logic        SCAN_MODE,          // scan sequencer active
	input  wire logic [23:0] CONV_LEN,           // conversion length, clocks
	input  wire logic        CHECK_MISMATCH,     // config_checksum mismatch
	input  wire logic        REGMAP_LOCKED,      // register map locked
	input  wire logic        START_PULSE_ENABLE, // start_pulse_enable bit
	input  wire logic        PIN_SRC_SEL,        // pin source select bit
	input  wire logic        BITSTREAM_SEL,      // pin carries bitstream
	input  wire logic        MODULATOR_BITSTREAM_OUT, // modulator bit
	output logic             IRQ_N,              // interrupt pin level
	output logic      [7:0]  STATUS_FLAGS,       // status byte snapshot
	output logic      [7:0]  IRQ_REG_DATA,       // flag register snapshot
	output logic             SERIAL_READY        // serial port may answer
);
	localparam int DRB = irq_flag_pkg::FLAG_DR_BIT;
	localparam int CFB = irq_flag_pkg::FLAG_CFG_BIT;
	localparam int PRB = irq_flag_pkg::FLAG_POR_BIT;
	localparam int NEV = irq_flag_pkg::EV_COUNT;
	localparam logic [7:0]  STARTUP_LAST = 8'(irq_flag_pkg::STARTUP_CLKS - 1);
	localparam logic [7:0]  STP_LAST     = 8'(STP_WIDTH - 1);
	localparam logic [23:0] DR_MARGIN    = 24'(irq_flag_pkg::DR_MARGIN_CLKS);

	logic [NEV-1:0] lk_ev;
	logic [NEV-1:0] ev;
	logic [2:0]     pins_s;
	logic           cs_s;
	logic           por_state;
	logic           cs_fall;

	// link strobes cross to the block clock
	assign lk_ev = {LK_FAST_START, LK_DATA_RD_EDGE, LK_IRQ_RD_END,
			LK_IRQ_RD_START, LK_STATUS_END, LK_ADDR_HIT};

	flag_evt_cross #(.W(NEV)) u_ev_cross (
		.src_clk   (SCK_CLK),
		.src_rst_n (RESETN),
		.src_pulse (lk_ev),
		.dst_clk   (REF_CLK),
		.dst_rst_n (RESETN),
		.dst_pulse (ev)
	);

	flag_sync2 #(.W(3), .RST_VAL(3'h1)) u_pin_sync (
		.clk   (REF_CLK),
		.rst_n (RESETN),
		.d     ({DVDD_OK, AVDD_OK, CS_N}),
		.q     (pins_s)
	);

	assign cs_s      = pins_s[0];
	assign por_state = !(pins_s[1] && pins_s[2]);

	// ---------------- timers: start-up delay, start pulse, conversion
	logic        start_busy_r, start_busy_nxt;
	logic [7:0]  start_cnt_r, start_cnt_nxt;
	logic        stp_act_r, stp_act_nxt;
	logic [7:0]  stp_cnt_r, stp_cnt_nxt;
	logic [23:0] conv_cnt_r, conv_cnt_nxt;
	logic        cs_prev_r, cs_prev_nxt;
	logic        fire;
	logic        auto_rel;

	// one kick per sequence, so in scan mode only the first cycle pulses
	always_comb begin
		start_busy_nxt = start_busy_r;
		start_cnt_nxt  = start_cnt_r;
		stp_act_nxt    = stp_act_r;
		stp_cnt_nxt    = stp_cnt_r;
		conv_cnt_nxt   = conv_cnt_r;
		cs_prev_nxt    = cs_s;
		fire           = 1'b0;
		if (CONV_KICK) begin
			start_busy_nxt = 1'b1;
			start_cnt_nxt  = 8'h00;
		end else if (start_busy_r) begin
			start_cnt_nxt = start_cnt_r + 8'h01;
			if (start_cnt_r == STARTUP_LAST) begin
				start_busy_nxt = 1'b0;
				fire           = 1'b1;
			end
		end
		if (fire && START_PULSE_ENABLE) begin
			stp_act_nxt = 1'b1;
			stp_cnt_nxt = 8'h00;
		end else if (stp_act_r) begin
			stp_cnt_nxt = stp_cnt_r + 8'h01;
			if (stp_cnt_r == STP_LAST) begin
				stp_act_nxt = 1'b0;
			end
		end
		if (fire || CONV_DONE) begin
			conv_cnt_nxt = CONV_LEN;
		end else if (conv_cnt_r != 24'h000000) begin
			conv_cnt_nxt = conv_cnt_r - 24'h000001;
		end
		if (!RESETN) begin
			start_busy_nxt = 1'b0;
			start_cnt_nxt  = 8'h00;
			stp_act_nxt    = 1'b0;
			stp_cnt_nxt    = 8'h00;
			conv_cnt_nxt   = 24'h000000;
			cs_prev_nxt    = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		start_busy_r <= start_busy_nxt;
		start_cnt_r  <= start_cnt_nxt;
		stp_act_r    <= stp_act_nxt;
		stp_cnt_r    <= stp_cnt_nxt;
		conv_cnt_r   <= conv_cnt_nxt;
		cs_prev_r    <= cs_prev_nxt;
	end

	assign cs_fall  = cs_prev_r && !cs_s;
	assign auto_rel = (CONT_MODE || SCAN_MODE) && (conv_cnt_r == DR_MARGIN);

	// ---------------- flags, snapshots and pin
	logic       dr_st_r, dr_st_nxt, cf_st_r, cf_st_nxt, po_st_r, po_st_nxt;
	logic       dr_rg_r, dr_rg_nxt, cf_rg_r, cf_rg_nxt, po_rg_r, po_rg_nxt;
	logic [7:0] st_snap_r, st_snap_nxt;
	logic [7:0] rg_snap_r, rg_snap_nxt;
	logic       por_pin_r, por_pin_nxt;
	logic       cfg_pin_r, cfg_pin_nxt;
	logic       dr_pin_r, dr_pin_nxt;
	logic       irq_n_r, irq_n_nxt;
	logic       ready_r, ready_nxt;
	logic       st_end, rg_end;

	// the serial port is dead while in power-on state
	assign st_end = ev[irq_flag_pkg::EV_STAT_END] && ready_r;
	assign rg_end = ev[irq_flag_pkg::EV_IRQ_END] && ready_r;

	always_comb begin
		st_snap_nxt = st_snap_r;
		rg_snap_nxt = rg_snap_r;
		// status path: event wins over the end-of-byte clear
		dr_st_nxt = CONV_DONE ? irq_flag_pkg::FLAG_PEND :
			(st_end && !st_snap_r[DRB]) ? irq_flag_pkg::FLAG_IDLE : dr_st_r;
		cf_st_nxt = cfg_pin_r ? irq_flag_pkg::FLAG_PEND :
			(st_end && !st_snap_r[CFB]) ? irq_flag_pkg::FLAG_IDLE : cf_st_r;
		po_st_nxt = por_state ? irq_flag_pkg::FLAG_PEND :
			(st_end && !st_snap_r[PRB]) ? irq_flag_pkg::FLAG_IDLE : po_st_r;
		// register path, cleared only by the end of a flag register read
		dr_rg_nxt = CONV_DONE ? irq_flag_pkg::FLAG_PEND :
			(rg_end && !rg_snap_r[DRB]) ? irq_flag_pkg::FLAG_IDLE : dr_rg_r;
		cf_rg_nxt = cfg_pin_r ? irq_flag_pkg::FLAG_PEND :
			(rg_end && !rg_snap_r[CFB]) ? irq_flag_pkg::FLAG_IDLE : cf_rg_r;
		po_rg_nxt = por_state ? irq_flag_pkg::FLAG_PEND :
			(rg_end && !rg_snap_r[PRB]) ? irq_flag_pkg::FLAG_IDLE : po_rg_r;
		if (ev[irq_flag_pkg::EV_ADDR_HIT] && ready_r) begin
			st_snap_nxt      = 8'h00;
			st_snap_nxt[DRB] = dr_st_r;
			st_snap_nxt[CFB] = cf_st_r;
			st_snap_nxt[PRB] = po_st_r;
		end
		if (ev[irq_flag_pkg::EV_IRQ_START] && ready_r) begin
			rg_snap_nxt      = 8'h00;
			rg_snap_nxt[DRB] = dr_rg_r;
			rg_snap_nxt[CFB] = cf_rg_r;
			rg_snap_nxt[PRB] = po_rg_r;
		end
		// pin indications
		por_pin_nxt = por_state ? 1'b1 : cs_fall ? 1'b0 : por_pin_r;
		if (CHECK_MISMATCH && REGMAP_LOCKED) begin
			cfg_pin_nxt = 1'b1;
		end else if (!REGMAP_LOCKED || ev[irq_flag_pkg::EV_FAST_START]) begin
			cfg_pin_nxt = 1'b0;
		end else begin
			cfg_pin_nxt = cfg_pin_r;
		end
		dr_pin_nxt = CONV_DONE ? 1'b1 :
			(ev[irq_flag_pkg::EV_DATA_EDGE] || auto_rel) ? 1'b0 : dr_pin_r;
		// pin priority: por, check error, bitstream, then selectable sources
		if (por_pin_nxt || cfg_pin_nxt) begin
			irq_n_nxt = 1'b0;
		end else if (BITSTREAM_SEL) begin
			irq_n_nxt = MODULATOR_BITSTREAM_OUT;
		end else if (!PIN_SRC_SEL && (dr_pin_nxt || stp_act_nxt)) begin
			irq_n_nxt = 1'b0;
		end else begin
			irq_n_nxt = 1'b1;
		end
		ready_nxt = !por_state;
		if (!RESETN) begin
			dr_st_nxt   = irq_flag_pkg::FLAG_IDLE;
			cf_st_nxt   = irq_flag_pkg::FLAG_IDLE;
			po_st_nxt   = irq_flag_pkg::FLAG_PEND;
			dr_rg_nxt   = irq_flag_pkg::FLAG_IDLE;
			cf_rg_nxt   = irq_flag_pkg::FLAG_IDLE;
			po_rg_nxt   = irq_flag_pkg::FLAG_PEND;
			st_snap_nxt = irq_flag_pkg::SNAP_RST;
			rg_snap_nxt = irq_flag_pkg::SNAP_RST;
			por_pin_nxt = 1'b1;
			cfg_pin_nxt = 1'b0;
			dr_pin_nxt  = 1'b0;
			irq_n_nxt   = 1'b0;
			ready_nxt   = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		dr_st_r   <= dr_st_nxt;
		cf_st_r   <= cf_st_nxt;
		po_st_r   <= po_st_nxt;
		dr_rg_r   <= dr_rg_nxt;
		cf_rg_r   <= cf_rg_nxt;
		po_rg_r   <= po_rg_nxt;
		st_snap_r <= st_snap_nxt;
		rg_snap_r <= rg_snap_nxt;
		por_pin_r <= por_pin_nxt;
		cfg_pin_r <= cfg_pin_nxt;
		dr_pin_r  <= dr_pin_nxt;
		irq_n_r   <= irq_n_nxt;
		ready_r   <= ready_nxt;
	end

	assign IRQ_N        = irq_n_r;
	assign STATUS_FLAGS = st_snap_r;
	assign IRQ_REG_DATA = rg_snap_r;
	assign SERIAL_READY = ready_r;

	// ---------------- checks
	chk_dr_event_flags: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		CONV_DONE |=> !dr_st_r && !dr_rg_r && dr_pin_r)
		else $error("data ready event did not set flags");
	chk_stat_clear: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		st_end && !st_snap_r[DRB] && !CONV_DONE |=> dr_st_r)
		else $error("status data ready not cleared at byte end");
	chk_reg_clear: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		rg_end && !rg_snap_r[PRB] && !por_state |=> po_rg_r)
		else $error("register power flag not cleared at read end");
	chk_cfg_hold: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		cfg_pin_r |=> !cf_st_r && !cf_rg_r)
		else $error("check error flag dropped while pending");
	chk_cfg_pin_prio: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		cfg_pin_r ##1 cfg_pin_r |-> !IRQ_N)
		else $error("check error did not hold pin low");
	chk_pin_select: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		PIN_SRC_SEL && !BITSTREAM_SEL && !por_pin_nxt && !cfg_pin_nxt
		|=> IRQ_N)
		else $error("masked source drove the pin");
	chk_start_delay: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		$rose(stp_act_r) |-> $past(start_cnt_r) == STARTUP_LAST)
		else $error("start pulse not after start-up delay");
	chk_start_width: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		$fell(stp_act_r) && !$past(fire) |-> $past(stp_cnt_r) == STP_LAST)
		else $error("start pulse width wrong");
	chk_dr_margin: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		auto_rel && !CONV_DONE |=> !dr_pin_r)
		else $error("data ready pin not released before end");
	chk_por_pin: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		cs_fall && !por_state |=> !por_pin_r ##1 1'b1)
		else $error("por pin not cleared by select fall");
	// snapshots, serial port and pin sources
	chk_stat_hold: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		!(ev[irq_flag_pkg::EV_ADDR_HIT] && ready_r)
		|=> $stable(STATUS_FLAGS))
		else $error("status byte changed without snapshot");
	chk_reg_hold: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		!(ev[irq_flag_pkg::EV_IRQ_START] && ready_r)
		|=> $stable(IRQ_REG_DATA))
		else $error("flag register changed without snapshot");
	chk_stat_snap: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		ev[irq_flag_pkg::EV_ADDR_HIT] && ready_r |=>
		{STATUS_FLAGS[DRB], STATUS_FLAGS[CFB], STATUS_FLAGS[PRB]}
		== $past({dr_st_r, cf_st_r, po_st_r}))
		else $error("status byte snapshot wrong");
	chk_reg_snap: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		ev[irq_flag_pkg::EV_IRQ_START] && ready_r |=>
		{IRQ_REG_DATA[DRB], IRQ_REG_DATA[CFB], IRQ_REG_DATA[PRB]}
		== $past({dr_rg_r, cf_rg_r, po_rg_r}))
		else $error("flag register snapshot wrong");
	chk_por_dead: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		por_state |=> !SERIAL_READY && !po_st_r && !po_rg_r)
		else $error("serial port or power flags live in power-on state");
	chk_por_pin_low: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		por_state |=> por_pin_r && !IRQ_N)
		else $error("pin not low in power-on state");
	chk_dr_pin_low: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		CONV_DONE && !PIN_SRC_SEL && !BITSTREAM_SEL |=> !IRQ_N)
		else $error("data ready did not pull the pin low");
	chk_cfg_set: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		CHECK_MISMATCH && REGMAP_LOCKED |=> cfg_pin_r && !IRQ_N)
		else $error("check error not raised while locked");
	chk_cfg_clear: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		!CHECK_MISMATCH && (!REGMAP_LOCKED || ev[irq_flag_pkg::EV_FAST_START])
		|=> !cfg_pin_r)
		else $error("check error pin not cleared");
	chk_dr_read_rel: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		ev[irq_flag_pkg::EV_DATA_EDGE] && !CONV_DONE |=> !dr_pin_r)
		else $error("data ready pin not released by result read");
	chk_start_off: assert property (
		@(posedge REF_CLK) disable iff (!RESETN)
		!START_PULSE_ENABLE && !stp_act_r |=> !stp_act_r)
		else $error("start pulse while disabled");
endmodule // adc_irq_flags
`default_nettype wire

//--- hw/irq_flag_pkg.sv
// Purpose: shared constants of the converter interrupt flag logic
// Assumes: modulator clock is the block clock
// Notes:   flag bits are active low, 1 means no pending event
package irq_flag_pkg;
	// register address of the interrupt flag register
	localparam logic [3:0] IRQ_REG_ADDR   = 4'h5;
	// bit positions shared by the status byte and the interrupt register
	localparam int         FLAG_DR_BIT    = 4;
	localparam int         FLAG_CFG_BIT   = 3;
	localparam int         FLAG_POR_BIT   = 2;
	// values after reset
	localparam logic [7:0] SNAP_RST       = 8'h00;
	localparam logic       FLAG_IDLE      = 1'b1;
	localparam logic       FLAG_PEND      = 1'b0;
	// timing in modulator clock periods, and conversion length width in bits
	localparam int         STARTUP_CLKS   = 256;
	localparam int         DR_MARGIN_CLKS = 16;
	localparam int         STP_WIDTH_DEF  = 4;
	localparam int         CONV_LEN_W     = 24;
	// link event indices
	localparam int         EV_ADDR_HIT    = 0;
	localparam int         EV_STAT_END    = 1;
	localparam int         EV_IRQ_START   = 2;
	localparam int         EV_IRQ_END     = 3;
	localparam int         EV_DATA_EDGE   = 4;
	localparam int         EV_FAST_START  = 5;
	localparam int         EV_COUNT       = 6;
endpackage

//--- hw/flag_sync2.sv
// Purpose: two flip-flop level synchroniser, one per bit
// Assumes: inputs are levels from another domain or a pin
// Notes:   the first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module flag_sync2 #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         clk,     // destination clock
	input  wire logic         rst_n,   // synchronous reset, active low
	input  wire logic [W-1:0] d,       // asynchronous levels
	output logic      [W-1:0] q        // synchronised levels
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	always_comb begin
		meta_nxt = rst_n ? d : RST_VAL;
		q_nxt    = rst_n ? meta_r : RST_VAL;
	end

	always_ff @(posedge clk) begin
		meta_r <= meta_nxt;
		q_r    <= q_nxt;
	end

	assign q = q_r;
endmodule // flag_sync2
`default_nettype wire

//--- hw/flag_evt_cross.sv
// Purpose: carry one-cycle strobes from the link clock to the block clock
// Assumes: strobes on one bit are at least three block cycles apart
// Notes:   toggle crossing; destination ignores toggles while priming
`timescale 1ns/1ps
`default_nettype none
module flag_evt_cross #(
	parameter int             W = 1
) (
	input  wire logic         src_clk,   // link clock
	input  wire logic         src_rst_n, // link side reset, active low
	input  wire logic [W-1:0] src_pulse, // strobes in link domain
	input  wire logic         dst_clk,   // block clock
	input  wire logic         dst_rst_n, // block side reset, active low
	output logic      [W-1:0] dst_pulse  // strobes in block domain
);
	logic [W-1:0] tog_r;
	logic [W-1:0] tog_nxt;
	logic [W-1:0] tog_s;
	logic [W-1:0] last_r;
	logic [W-1:0] last_nxt;
	logic [W-1:0] pulse_r;
	logic [W-1:0] pulse_nxt;
	logic [1:0]   prime_r;
	logic [1:0]   prime_nxt;

	always_comb begin
		tog_nxt = src_rst_n ? (tog_r ^ src_pulse) : '0;
	end

	always_ff @(posedge src_clk) begin
		tog_r <= tog_nxt;
	end

	flag_sync2 #(.W(W), .RST_VAL('0)) u_sync (
		.clk   (dst_clk),
		.rst_n (dst_rst_n),
		.d     (tog_r),
		.q     (tog_s)
	);

	// after reset the link side may hold a stale toggle; adopt it silently
	always_comb begin
		last_nxt  = tog_s;
		pulse_nxt = (prime_r == 2'h3) ? (tog_s ^ last_r) : '0;
		prime_nxt = (prime_r == 2'h3) ? prime_r : prime_r + 2'h1;
		if (!dst_rst_n) begin
			pulse_nxt = '0;
			prime_nxt = 2'h0;
		end
	end

	always_ff @(posedge dst_clk) begin
		last_r  <= last_nxt;
		pulse_r <= pulse_nxt;
		prime_r <= prime_nxt;
	end

	assign dst_pulse = pulse_r;
endmodule // flag_evt_cross
`default_nettype wire

//--- tb/host_link_model.sv
// Purpose: host side serial master model, drives chip select and strobes
// Assumes: decoder strobes last one link clock each
// Notes:   link clock stands still outside frames, runs during reset
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
	input  wire logic rst_n,  // bench reset, active low
	output logic      sck,    // link clock
	output logic      cs_n,   // chip select, active low
	output logic [5:0] strobe // command decoder strobes
);
	logic run;

	initial begin
		cs_n = 1'b1;
		strobe = '0;
		run = 1'b0;
	end

	// 12 ns period, phase offset against the block clock
	initial begin
		sck = 1'b0;
		#1.7;
		forever begin
			#6;
			sck = (run | ~rst_n) ? ~sck : 1'b0;
		end
	end

	// one command frame, up to two strobes three link clocks apart
	task automatic frame(input int a, input int b);
		cs_n = 1'b0;
		run = 1'b1;
		repeat (2) @(posedge sck);
		#1 strobe[a] = 1'b1;
		@(posedge sck);
		#1 strobe = '0;
		if (b >= 0) begin
			repeat (3) @(posedge sck);
			#1 strobe[b] = 1'b1;
			@(posedge sck);
			#1 strobe = '0;
		end
		repeat (2) @(posedge sck);
		#1 cs_n = 1'b1;
		run = 1'b0;
	endtask
endmodule // host_link_model
`default_nettype wire

//--- tb/adc_irq_flags_tb.sv
// Purpose: self-checking bench of the converter interrupt flags
// Assumes: host model supplies the link strobes and chip select
// Notes:   start pulse width shortened to 3 cycles
`timescale 1ns/1ps
`default_nettype none
module adc_irq_flags_tb;
	localparam int STP_W = 3;
	localparam int LEN   = 40;
	logic        ref_clk, resetn, avdd_ok, dvdd_ok, conv_kick, conv_done;
	logic        cont_mode, scan_mode, check_mismatch, regmap_locked;
	logic        start_pulse_enable, pin_src_sel, bitstream_sel, bit_out;
	logic        sck, cs_n, irq_n, serial_ready;
	logic [5:0]  strobe;
	logic [7:0]  status_flags, irq_reg_data;
	int          n_fail, checked;

	adc_irq_flags #(.STP_WIDTH(STP_W)) i_adc_irq_flags (
		.REF_CLK(ref_clk), .RESETN(resetn), .SCK_CLK(sck), .CS_N(cs_n),
		.AVDD_OK(avdd_ok), .DVDD_OK(dvdd_ok),
		.LK_ADDR_HIT(strobe[irq_flag_pkg::EV_ADDR_HIT]),
		.LK_STATUS_END(strobe[irq_flag_pkg::EV_STAT_END]),
		.LK_IRQ_RD_START(strobe[irq_flag_pkg::EV_IRQ_START]),
		.LK_IRQ_RD_END(strobe[irq_flag_pkg::EV_IRQ_END]),
		.LK_DATA_RD_EDGE(strobe[irq_flag_pkg::EV_DATA_EDGE]),
		.LK_FAST_START(strobe[irq_flag_pkg::EV_FAST_START]),
		.CONV_KICK(conv_kick), .CONV_DONE(conv_done), .CONT_MODE(cont_mode),
		.SCAN_MODE(scan_mode), .CONV_LEN(24'(LEN)),
		.CHECK_MISMATCH(check_mismatch), .REGMAP_LOCKED(regmap_locked),
		.START_PULSE_ENABLE(start_pulse_enable), .PIN_SRC_SEL(pin_src_sel),
		.BITSTREAM_SEL(bitstream_sel), .MODULATOR_BITSTREAM_OUT(bit_out),
		.IRQ_N(irq_n), .STATUS_FLAGS(status_flags),
		.IRQ_REG_DATA(irq_reg_data), .SERIAL_READY(serial_ready));

	host_link_model i_host_link_model (
		.rst_n(resetn), .sck(sck), .cs_n(cs_n), .strobe(strobe));

	initial ref_clk = 1'b0;
	always #2.5 ref_clk = ~ref_clk;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp,
		input string what);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	function automatic logic [7:0] fb(input logic dr, cfg, por);
		fb = 8'h00;
		fb[irq_flag_pkg::FLAG_DR_BIT] = dr;
		fb[irq_flag_pkg::FLAG_CFG_BIT] = cfg;
		fb[irq_flag_pkg::FLAG_POR_BIT] = por;
	endfunction

	task automatic status_rd(input logic [7:0] exp, input string what);
		i_host_link_model.frame(irq_flag_pkg::EV_ADDR_HIT, irq_flag_pkg::EV_STAT_END);
		cyc(6);
		check(status_flags, exp, what);
	endtask

	task automatic reg_rd(input logic [7:0] exp, input string what);
		i_host_link_model.frame(irq_flag_pkg::EV_IRQ_START, irq_flag_pkg::EV_IRQ_END);
		cyc(6);
		check(irq_reg_data, exp, what);
	endtask

	task automatic send_one(input int ev);
		i_host_link_model.frame(ev, -1);
		cyc(6);
	endtask

	task automatic pulse_done;
		conv_done = 1'b1;
		cyc(1);
		conv_done = 1'b0;
		cyc(2);
	endtask

	task automatic t_power_up;
		check(serial_ready, 1'b1, "ready after reset");
		check(irq_n, 1'b0, "por pin after reset");
		status_rd(fb(1, 1, 0), "first status byte");
		check(irq_n, 1'b1, "por pin cleared by cs");
		status_rd(fb(1, 1, 1), "second status byte");
		reg_rd(fb(1, 1, 0), "first register read");
		reg_rd(fb(1, 1, 1), "second register read");
		$display("test power_up finished");
	endtask

	task automatic t_data_ready;
		pulse_done();
		check(irq_n, 1'b0, "data ready pin");
		status_rd(fb(0, 1, 1), "conv_ready_flag_n");
		status_rd(fb(1, 1, 1), "conv_ready_flag_n again");
		reg_rd(fb(0, 1, 1), "dr register");
		reg_rd(fb(1, 1, 1), "dr register again");
		check(irq_n, 1'b0, "dr pin held");
		send_one(irq_flag_pkg::EV_DATA_EDGE);
		check(irq_n, 1'b1, "dr pin released by read");
		$display("test data_ready finished");
	endtask

	task automatic t_auto_release;
		for (int m = 0; m < 2; m++) begin
			cont_mode = (m == 0);
			scan_mode = (m == 1);
			conv_done = 1'b1;
			cyc(1);
			conv_done = 1'b0;
			cyc(LEN - 22);
			check(irq_n, 1'b0, "dr pin before margin");
			cyc(10);
			check(irq_n, 1'b1, "dr pin auto release");
			status_rd(fb(0, 1, 1), "conv_ready_flag_n auto");
			reg_rd(fb(0, 1, 1), "dr register auto");
		end
		cont_mode = 1'b0;
		scan_mode = 1'b0;
		$display("test auto_release finished");
	endtask

	task automatic t_pin_select;
		pin_src_sel = 1'b1;
		pulse_done();
		check(irq_n, 1'b1, "dr kept off pin");
		status_rd(fb(0, 1, 1), "conv_ready_flag_n masked pin");
		reg_rd(fb(0, 1, 1), "dr register masked pin");
		send_one(irq_flag_pkg::EV_DATA_EDGE);
		pin_src_sel = 1'b0;
		cyc(2);
		check(irq_n, 1'b1, "pin idle after select");
		$display("test pin_select finished");
	endtask

	task automatic t_start_pulse;
		int first;
		int lows;
		for (int en = 1; en >= 0; en--) begin
			start_pulse_enable = en[0];
			first = -1;
			lows = 0;
			conv_kick = 1'b1;
			cyc(1);
			conv_kick = 1'b0;
			for (int i = 1; i < 300; i++) begin
				cyc(1);
				if (irq_n === 1'b0) begin
					lows++;
					if (first < 0)
						first = i;
				end
			end
			check(lows[7:0], en ? 8'(STP_W) : 8'h00, "start pulse width");
			if (en == 1)
				check(first >= 254 && first <= 260, 1'b1, "start delay");
		end
		start_pulse_enable = 1'b1;
		status_rd(fb(1, 1, 1), "no start in status");
		reg_rd(fb(1, 1, 1), "no start in register");
		$display("test start_pulse finished");
	endtask

	task automatic t_check_error;
		regmap_locked = 1'b1;
		check_mismatch = 1'b1;
		cyc(1);
		check_mismatch = 1'b0;
		cyc(2);
		check(irq_n, 1'b0, "check error pin");
		bitstream_sel = 1'b1;
		bit_out = 1'b1;
		pin_src_sel = 1'b1;
		cyc(2);
		check(irq_n, 1'b0, "error over bitstream");
		status_rd(fb(1, 0, 1), "error status");
		reg_rd(fb(1, 0, 1), "error register");
		status_rd(fb(1, 0, 1), "error status held");
		send_one(irq_flag_pkg::EV_FAST_START);
		check(irq_n, 1'b1, "fast start clears pin");
		bit_out = 1'b0;
		cyc(2);
		check(irq_n, 1'b0, "bitstream on pin");
		bit_out = 1'b1;
		send_one(irq_flag_pkg::EV_ADDR_HIT);
		send_one(irq_flag_pkg::EV_STAT_END);
		reg_rd(fb(1, 0, 1), "error register after fast start");
		status_rd(fb(1, 1, 1), "error status cleared");
		check_mismatch = 1'b1;
		cyc(1);
		check_mismatch = 1'b0;
		cyc(2);
		check(irq_n, 1'b0, "second error pin");
		regmap_locked = 1'b0;
		cyc(3);
		check(irq_n, 1'b1, "unlock clears pin");
		bitstream_sel = 1'b0;
		pin_src_sel = 1'b0;
		send_one(irq_flag_pkg::EV_ADDR_HIT);
		send_one(irq_flag_pkg::EV_STAT_END);
		reg_rd(fb(1, 0, 1), "second error register");
		status_rd(fb(1, 1, 1), "error status clear again");
		$display("test check_error finished");
	endtask

	task automatic t_supply_drop;
		for (int s = 0; s < 2; s++) begin
			avdd_ok = (s == 1);
			dvdd_ok = (s == 0);
			cyc(5);
			check(irq_n, 1'b0, "por pin on drop");
			check(serial_ready, 1'b0, "serial off in por");
			status_rd(fb(1, 1, 1), "no answer in por");
			check(irq_n, 1'b0, "cs fall with bad supply");
			avdd_ok = 1'b1;
			dvdd_ok = 1'b1;
			cyc(6);
			check(serial_ready, 1'b1, "serial back");
			check(irq_n, 1'b0, "por pin until cs");
			status_rd(fb(1, 1, 0), "por status");
			check(irq_n, 1'b1, "por pin cleared");
			reg_rd(fb(1, 1, 0), "por register");
			reg_rd(fb(1, 1, 1), "por register again");
			status_rd(fb(1, 1, 1), "por status again");
		end
		$display("test supply_drop finished");
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		n_fail = 0;
		checked = 0;
		resetn = 1'b0;
		{avdd_ok, dvdd_ok, start_pulse_enable} = 3'b111;
		{conv_kick, conv_done, cont_mode, scan_mode} = 4'h0;
		{check_mismatch, regmap_locked, pin_src_sel} = 3'b000;
		{bitstream_sel, bit_out} = 2'b00;
		cyc(4);
		resetn = 1'b1;
		cyc(10);
		t_power_up();
		t_data_ready();
		t_auto_release();
		t_pin_select();
		t_start_pulse();
		t_check_error();
		t_supply_drop();
		finish_test();
	end

	// all tests take well under 30 us
	initial begin
		#100000;
		n_fail++;
		$display("Error at %0t: watchdog expired", $time);
		finish_test();
	end
endmodule // adc_irq_flags_tb
`default_nettype wire
